// >>> inc/cg_consts.vh
// Field layout and reset values of the clock generator configuration word.
`ifndef CG_CONSTS_VH
`define CG_CONSTS_VH
`define CG_PLLS        4
`define CG_OUTS        5
`define CG_PLL_STRIDE  32
`define CG_REF_LSB     0
`define CG_FB_LSB      8
`define CG_RZ_LSB      19
`define CG_CZ_LSB      24
`define CG_CP_LSB      27
`define CG_IP_LSB      29
`define CG_OUT_BASE    128
`define CG_OUT_STRIDE  15
`define CG_OUTPUT_DIVIDE_TOTAL_LSB    0
`define CG_OSRC_LSB    8
`define CG_OEN_BIT     11
`define CG_OSLEW_LSB   12
`define CG_OINV_BIT    14
`define CG_FEEDBACK_PRESCALE_W      4
`define CG_FEEDBACK_PRESCALE_A_LSB  203
`define CG_FEEDBACK_PRESCALE_D_LSB  207
`define CG_SSEN_N_BIT  211
`define CG_SSMODE_BIT  212
`define CG_NC_LSB      213
`define CG_MOD_LSB     224
`define CG_NSS_LSB     237
`define CG_XTAL_N_BIT  248
`define CG_CFG_W       249
`define CG_SRC_REF     3'h4
`define CG_DEF_OUT     3
`define CG_SEL_SLEEP   2'h0
`endif

// >>> hw/cg_cfg_mem.v
// Configuration store holding one word per select value, registered read.
`timescale 1ns/100ps
`default_nettype none
module cg_cfg_mem #(
  parameter W       = 8,
  parameter DEPTH   = 4,
  parameter AW      = 2,
  parameter [W-1:0] DEFAULT = {W{1'b0}}
) (
  input  wire          mclk_in,
  input  wire          rst_n_in,
  input  wire          wr_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [W-1:0]  wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [W-1:0]  rd_data_out
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  integer i;

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_r[i] <= DEFAULT;
      rd_data_out <= DEFAULT;
    end
    else
    begin
      if (wr_in)
        mem_r[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem_r[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

// >>> hw/cg_nco.v
// Phase accumulator standing in for one PLL: ticks at inc/thr of mclk rate.
`timescale 1ns/100ps
`default_nettype none
module cg_nco #(
  parameter ACC_W = 24
) (
  input  wire             mclk_in,
  input  wire             rst_n_in,
  input  wire             run_in,
  input  wire [ACC_W-1:0] inc_in,
  input  wire [ACC_W-1:0] thr_in,
  output reg              tick_out
);
  reg  [ACC_W-1:0] acc_r;
  wire [ACC_W:0]   sum = {1'b0, acc_r} + {1'b0, inc_in};

  always @(posedge mclk_in)
  begin
    if (!rst_n_in || !run_in)
    begin
      acc_r    <= {ACC_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (inc_in >= thr_in)
    begin
      acc_r    <= {ACC_W{1'b0}};
      tick_out <= 1'b1;
    end
    else if (sum >= {1'b0, thr_in})
    begin
      acc_r    <= sum[ACC_W-1:0] - thr_in;
      tick_out <= 1'b1;
    end
    else
    begin
      acc_r    <= sum[ACC_W-1:0];
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hw/cg_clock_gen.v
// Four-PLL clock generator: configuration slots, dividers, spread, outputs.
`timescale 1ns/100ps
`default_nettype none
`include "cg_consts.vh"
module cg_clock_gen #(
  parameter VCO_SCALE = 64,
  parameter ACC_W     = 24
) (
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire [1:0]  cfg_sel_in,
  input  wire        cfg_wr_in,
  input  wire [1:0]  cfg_slot_in,
  input  wire [31:0] ref_div_in,
  input  wire [43:0] fb_div_in,
  input  wire [3:0]  feedback_prescale_a_in,
  input  wire [3:0]  feedback_prescale_d_in,
  input  wire [19:0] loop_zero_resistor_in,
  input  wire [11:0] loop_zero_capacitor_in,
  input  wire [7:0]  loop_pole_capacitor_in,
  input  wire [11:0] charge_pump_current_in,
  input  wire [39:0] out_div_in,
  input  wire [14:0] out_src_in,
  input  wire [4:0]  out_en_in,
  input  wire [9:0]  out_slew_in,
  input  wire [4:0]  out_inv_in,
  input  wire        spread_enable_n_in,
  input  wire        spread_std_mode_in,
  input  wire [10:0] spread_cycles_in,
  input  wire [12:0] spread_mid_ratio_in,
  input  wire [10:0] spread_amplitude_in,
  input  wire        crystal_osc_enable_n_in,
  output wire [4:0]  clk_out,
  output wire [4:0]  clk_oe_out,
  output wire [9:0]  out_slew_out,
  output wire [19:0] loop_zero_resistor_out,
  output wire [11:0] loop_zero_capacitor_out,
  output wire [7:0]  loop_pole_capacitor_out,
  output wire [11:0] charge_pump_current_out,
  output reg         sleep_out,
  output reg         spread_active_out,
  output wire [3:0]  pll_tick_out
);
  localparam W  = `CG_CFG_W;
  localparam DW = 22;
  localparam OB = `CG_OUT_BASE + `CG_DEF_OUT * `CG_OUT_STRIDE;
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  // Unity dividers everywhere, spread off, output three on the reference.
  localparam [W-1:0] DEFAULT =
      (ONE << (0 * `CG_PLL_STRIDE + `CG_REF_LSB))
    | (ONE << (1 * `CG_PLL_STRIDE + `CG_REF_LSB))
    | (ONE << (2 * `CG_PLL_STRIDE + `CG_REF_LSB))
    | (ONE << (3 * `CG_PLL_STRIDE + `CG_REF_LSB))
    | (ONE << (0 * `CG_PLL_STRIDE + `CG_FB_LSB))
    | (ONE << (1 * `CG_PLL_STRIDE + `CG_FB_LSB))
    | (ONE << (2 * `CG_PLL_STRIDE + `CG_FB_LSB))
    | (ONE << (3 * `CG_PLL_STRIDE + `CG_FB_LSB))
    | (ONE << `CG_FEEDBACK_PRESCALE_A_LSB)
    | (ONE << `CG_FEEDBACK_PRESCALE_D_LSB)
    | (ONE << (OB + `CG_OUTPUT_DIVIDE_TOTAL_LSB))
    | (ONE << (OB + `CG_OSRC_LSB + 2))
    | (ONE << (OB + `CG_OEN_BIT))
    | (ONE << `CG_SSEN_N_BIT);

  function [7:0] at_least_one8;
    input [7:0] v;
    begin
      at_least_one8 = (v == 8'h00) ? 8'h01 : v;
    end
  endfunction

  // Synchronised select pins.
  reg  [1:0] sel_meta_r;
  reg  [1:0] sel_r;
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sel_meta_r <= 2'h3;
      sel_r      <= 2'h3;
    end
    else
    begin
      sel_meta_r <= cfg_sel_in;
      sel_r      <= sel_meta_r;
    end
  end

  // Programming port word assembled from the field ports.
  reg [W-1:0] wr_word;
  integer k;
  always @*
  begin
    wr_word = {W{1'b0}};
    for (k = 0; k < `CG_PLLS; k = k + 1)
    begin
      wr_word[k*`CG_PLL_STRIDE+`CG_REF_LSB +: 8] = ref_div_in[k*8 +: 8];
      wr_word[k*`CG_PLL_STRIDE+`CG_FB_LSB +: 11] = fb_div_in[k*11 +: 11];
      wr_word[k*`CG_PLL_STRIDE+`CG_RZ_LSB +: 5] =
        loop_zero_resistor_in[k*5 +: 5];
      wr_word[k*`CG_PLL_STRIDE+`CG_CZ_LSB +: 3] =
        loop_zero_capacitor_in[k*3 +: 3];
      wr_word[k*`CG_PLL_STRIDE+`CG_CP_LSB +: 2] =
        loop_pole_capacitor_in[k*2 +: 2];
      wr_word[k*`CG_PLL_STRIDE+`CG_IP_LSB +: 3] =
        charge_pump_current_in[k*3 +: 3];
    end
    for (k = 0; k < `CG_OUTS; k = k + 1)
    begin
      wr_word[`CG_OUT_BASE+k*`CG_OUT_STRIDE+`CG_OUTPUT_DIVIDE_TOTAL_LSB +: 8] =
        out_div_in[k*8 +: 8];
      wr_word[`CG_OUT_BASE+k*`CG_OUT_STRIDE+`CG_OSRC_LSB +: 3] =
        out_src_in[k*3 +: 3];
      wr_word[`CG_OUT_BASE+k*`CG_OUT_STRIDE+`CG_OEN_BIT] = out_en_in[k];
      wr_word[`CG_OUT_BASE+k*`CG_OUT_STRIDE+`CG_OSLEW_LSB +: 2] =
        out_slew_in[k*2 +: 2];
      wr_word[`CG_OUT_BASE+k*`CG_OUT_STRIDE+`CG_OINV_BIT] = out_inv_in[k];
    end
    wr_word[`CG_FEEDBACK_PRESCALE_A_LSB +: `CG_FEEDBACK_PRESCALE_W] = feedback_prescale_a_in;
    wr_word[`CG_FEEDBACK_PRESCALE_D_LSB +: `CG_FEEDBACK_PRESCALE_W] = feedback_prescale_d_in;
    wr_word[`CG_SSEN_N_BIT]    = spread_enable_n_in;
    wr_word[`CG_SSMODE_BIT]    = spread_std_mode_in;
    wr_word[`CG_NC_LSB +: 11]  = spread_cycles_in;
    wr_word[`CG_MOD_LSB +: 13] = spread_mid_ratio_in;
    wr_word[`CG_NSS_LSB +: 11] = spread_amplitude_in;
    wr_word[`CG_XTAL_N_BIT]    = crystal_osc_enable_n_in;
  end

  // Slot 0 is the sleep code and is never written.
  wire [W-1:0] cfg;
  cg_cfg_mem #(
    .W       (W),
    .DEPTH   (4),
    .AW      (2),
    .DEFAULT (DEFAULT)
  ) u_mem (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .wr_in       (cfg_wr_in && (cfg_slot_in != `CG_SEL_SLEEP)),
    .wr_addr_in  (cfg_slot_in),
    .wr_data_in  (wr_word),
    .rd_addr_in  (sel_r),
    .rd_data_out (cfg)
  );

  wire sleep   = (sel_r == `CG_SEL_SLEEP);
  // The read word lags the select by one edge, so waking waits one more.
  wire ref_run = !sleep && !sleep_out && !cfg[`CG_XTAL_N_BIT];

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
      sleep_out <= 1'b0;
    else
      sleep_out <= sleep;
  end

  // Spread modulator on the second PLL, stepped by its own output pulses.
  wire [10:0] nc      = cfg[`CG_NC_LSB +: 11];
  wire [12:0] mid     = cfg[`CG_MOD_LSB +: 13];
  wire [10:0] spread_amplitude     = cfg[`CG_NSS_LSB +: 11];
  wire [10:0] half    = {1'b0, nc[10:1]};
  wire [10:0] quarter = {2'b00, nc[10:2]};
  wire [10:0] amp     = (spread_amplitude > half) ? (spread_amplitude - half) : 11'h000;
  wire ss_on = ref_run && !cfg[`CG_SSEN_N_BIT] && (nc != 11'h000)
               && (mid != 13'h0000);
  reg  [10:0]   pos_r;
  reg  [DW-1:0] delta_r;
  reg  [DW-1:0] sd_r;
  reg  signed [1:0] adj_r;
  wire [3:0] tick;
  wire up = cfg[`CG_SSMODE_BIT] ? (pos_r >= half)
          : ((pos_r < quarter) || (pos_r >= half + quarter));
  wire [DW-1:0] mag = delta_r[DW-1] ? (~delta_r + 1'b1) : delta_r;
  wire [DW-1:0] sd_sum = sd_r + mag;
  wire [DW-1:0] mid_w  = {{(DW-13){1'b0}}, mid};

  always @(posedge mclk_in)
  begin
    if (!rst_n_in || !ss_on)
    begin
      pos_r   <= 11'h000;
      delta_r <= {DW{1'b0}};
      sd_r    <= {DW{1'b0}};
      adj_r   <= 2'sb00;
    end
    else
    begin
      if (tick[1])
      begin
        if (pos_r >= nc - 11'h001)
        begin
          pos_r   <= 11'h000;
          delta_r <= {DW{1'b0}};
        end
        else
        begin
          pos_r <= pos_r + 11'h001;
          if (up)
            delta_r <= delta_r + {{(DW-11){1'b0}}, amp};
          else
            delta_r <= delta_r - {{(DW-11){1'b0}}, amp};
        end
      end
      // Delta over mid ratio as a first-order sigma-delta ratio nudge.
      if (mag >= mid_w)
      begin
        sd_r  <= {DW{1'b0}};
        adj_r <= delta_r[DW-1] ? -2'sd1 : 2'sd1;
      end
      else if (sd_sum >= mid_w)
      begin
        sd_r  <= sd_sum - mid_w;
        adj_r <= delta_r[DW-1] ? -2'sd1 : 2'sd1;
      end
      else
      begin
        sd_r  <= sd_sum;
        adj_r <= 2'sb00;
      end
    end
  end

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
      spread_active_out <= 1'b0;
    else
      spread_active_out <= ss_on;
  end

  // The four PLLs, each modelled as a ratio accumulator.
  genvar g;
  generate
    for (g = 0; g < `CG_PLLS; g = g + 1)
    begin : pll
      wire [7:0]  rdiv = cfg[g*`CG_PLL_STRIDE+`CG_REF_LSB +: 8];
      wire [10:0] fdiv = cfg[g*`CG_PLL_STRIDE+`CG_FB_LSB +: 11];
      wire [`CG_FEEDBACK_PRESCALE_W-1:0] feedback_prescale = (g == 0) ? cfg[`CG_FEEDBACK_PRESCALE_A_LSB +: 4]
                                 : (g == 3) ? cfg[`CG_FEEDBACK_PRESCALE_D_LSB +: 4]
                                 : 4'h1;
      wire [ACC_W-1:0] base = feedback_prescale * fdiv;
      wire [31:0]      thr_w = at_least_one8(rdiv) * VCO_SCALE;
      wire [ACC_W-1:0] thr  = thr_w[ACC_W-1:0];
      wire [ACC_W-1:0] inc;
      if (g == 1)
      begin : ss
        assign inc = (adj_r == 2'sb01) ? base + 1'b1
                   : ((adj_r == -2'sd1) && (base != {ACC_W{1'b0}}))
                     ? base - 1'b1 : base;
      end
      else
      begin : plain
        assign inc = base;
      end
      cg_nco #(
        .ACC_W (ACC_W)
      ) u_nco (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .run_in   (ref_run),
        .inc_in   (inc),
        .thr_in   (thr),
        .tick_out (tick[g])
      );
    end
  endgenerate
  assign pll_tick_out = tick;

  // Loop filter fields go straight out to the analog controls.
  generate
    for (g = 0; g < `CG_PLLS; g = g + 1)
    begin : lf
      assign loop_zero_resistor_out[g*5 +: 5] =
        cfg[g*`CG_PLL_STRIDE+`CG_RZ_LSB +: 5];
      assign loop_zero_capacitor_out[g*3 +: 3] =
        cfg[g*`CG_PLL_STRIDE+`CG_CZ_LSB +: 3];
      assign loop_pole_capacitor_out[g*2 +: 2] =
        cfg[g*`CG_PLL_STRIDE+`CG_CP_LSB +: 2];
      assign charge_pump_current_out[g*3 +: 3] =
        cfg[g*`CG_PLL_STRIDE+`CG_IP_LSB +: 3];
    end
  endgenerate

  // Output banks: source select, divider, enable, inversion and slew.
  generate
    for (g = 0; g < `CG_OUTS; g = g + 1)
    begin : ob
      localparam B = `CG_OUT_BASE + g * `CG_OUT_STRIDE;
      wire [7:0] output_divide_total = at_least_one8(cfg[B+`CG_OUTPUT_DIVIDE_TOTAL_LSB +: 8]);
      wire [2:0] src  = cfg[B+`CG_OSRC_LSB +: 3];
      wire       en   = cfg[B+`CG_OEN_BIT] && !sleep && !sleep_out;
      wire       src_tick = (src == `CG_SRC_REF) ? ref_run
                          : (src < 3'h4) ? tick[src[1:0]]
                          : 1'b0;
      reg  [7:0] cnt_r;
      reg        lvl_r;
      reg        clk_r;
      reg        oe_r;
      reg  [1:0] slew_r;
      always @(posedge mclk_in)
      begin
        if (!rst_n_in || !en)
        begin
          cnt_r <= 8'h00;
          lvl_r <= 1'b0;
        end
        else if (src_tick)
        begin
          // A new divide value takes effect at once and may glitch.
          if (cnt_r >= output_divide_total - 8'h01)
          begin
            cnt_r <= 8'h00;
            lvl_r <= ~lvl_r;
          end
          else
            cnt_r <= cnt_r + 8'h01;
        end
      end
      always @(posedge mclk_in)
      begin
        if (!rst_n_in)
        begin
          clk_r  <= 1'b0;
          oe_r   <= 1'b0;
          slew_r <= 2'h0;
        end
        else
        begin
          clk_r  <= en & (lvl_r ^ cfg[B+`CG_OINV_BIT]);
          oe_r   <= en;
          slew_r <= cfg[B+`CG_OSLEW_LSB +: 2];
        end
      end
      assign clk_out[g]              = clk_r;
      assign clk_oe_out[g]           = oe_r;
      assign out_slew_out[g*2 +: 2]  = slew_r;
    end
  endgenerate
  // After reset every slot holds the default setup.
endmodule
`default_nettype wire

// >>> tb/pdsc_consumer.sv
// Clocked consumer that counts rising edges on each generated clock.
`timescale 1ns/100ps
`default_nettype none
module pdsc_consumer (
  input  wire logic       mclk_in,
  input  wire logic       clear_in,
  input  wire logic [4:0] clk_in,
  output var  logic [4:0][7:0] edges_out
);
  logic [4:0] prev_r;
  // Glitches from live divider changes only disturb the count.
  always @(posedge mclk_in)
  begin
    prev_r <= clk_in;
    for (int k = 0; k < 5; k++)
      if (clear_in)
        edges_out[k] <= 8'h00;
      else if (clk_in[k] && !prev_r[k])
        edges_out[k] <= edges_out[k] + 8'h01;
  end
endmodule
`default_nettype wire

// >>> tb/pdsc_assertions.sv
// Port checker for the clock generator top module.
`timescale 1ns/100ps
`default_nettype none
module pdsc_assertions #(
  parameter VCO_SCALE = 64,
  parameter ACC_W     = 24
) (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic [1:0] cfg_sel_in,
  input wire logic [4:0] clk_out,
  input wire logic [4:0] clk_oe_out,
  input wire logic       sleep_out,
  input wire logic       spread_active_out,
  input wire logic [3:0] pll_tick_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [3:0] since_rst_r;
  always @(posedge mclk_in)
    if (!rst_n_in)
      since_rst_r <= 4'h0;
    else if (since_rst_r != 4'hf)
      since_rst_r <= since_rst_r + 4'h1;
  sequence sel_held_sleep;
    (cfg_sel_in == 2'h0) [*6];
  endsequence
  sequence sel_held_awake;
    (cfg_sel_in != 2'h0) [*6];
  endsequence
  a_reset_clears_out: assert property ($rose(rst_n_in) |->
    clk_out == 5'h00 && clk_oe_out == 5'h00 && !sleep_out)
    else $error("outputs not cleared by reset");
  a_default_ref_out: assert property (since_rst_r == 4'hc |->
    clk_oe_out == 5'h08 && clk_out[3] != $past(clk_out[3]))
    else $error("default output three not toggling alone");
  a_sel_enters_sleep: assert property (sel_held_sleep |-> sleep_out)
    else $error("select 00 did not enter sleep");
  a_sel_leaves_sleep: assert property (sel_held_awake |-> !sleep_out)
    else $error("sleep with nonzero select");
  a_sleep_no_out: assert property (sleep_out [*2] |->
    clk_oe_out == 5'h00 && clk_out == 5'h00)
    else $error("output active in sleep");
  a_sleep_no_tick: assert property (sleep_out [*3] |-> pll_tick_out == 4'h0)
    else $error("pll ticking in sleep");
  a_oe_gates_clk: assert property ((clk_out & ~clk_oe_out) == 5'h00)
    else $error("disabled output high");
  a_sleep_no_spread: assert property (sleep_out [*3] |-> !spread_active_out)
    else $error("spread active in sleep");
endmodule
bind cg_clock_gen pdsc_assertions #(.VCO_SCALE(VCO_SCALE), .ACC_W(ACC_W)) chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cfg_sel_in(cfg_sel_in),
  .clk_out(clk_out), .clk_oe_out(clk_oe_out), .sleep_out(sleep_out),
  .spread_active_out(spread_active_out), .pll_tick_out(pll_tick_out));
`default_nettype wire

// >>> tb/pll_divider_spread_config_tb.sv
// Self-checking bench for the clock generator.
`timescale 1ns/100ps
`default_nettype none
module pll_divider_spread_config_tb;
  typedef struct packed {
    int         k;
    logic [2:0] src;
    logic [7:0] output_divide_total;
    logic [3:0] pre;
    logic [10:0] fb;
    logic [7:0] rdiv;
    logic       inv;
    logic [7:0] exp;
  } pdsc_row_t;
  logic        mclk_in, rst_n_in, cfg_wr_in, clear_r = 1'b0;
  logic [1:0]  cfg_sel_in = 2'h3, cfg_slot_in = 2'h1;
  logic [31:0] ref_div_in = 32'h0;
  logic [43:0] fb_div_in = 44'h0;
  logic [3:0]  feedback_prescale_a_in = 4'h1, feedback_prescale_d_in = 4'h1;
  logic [19:0] loop_zero_resistor_in = 20'h0, loop_zero_resistor_out;
  logic [11:0] loop_zero_capacitor_in = 12'h0, loop_zero_capacitor_out;
  logic [7:0]  loop_pole_capacitor_in = 8'h0, loop_pole_capacitor_out;
  logic [11:0] charge_pump_current_in = 12'h0, charge_pump_current_out;
  logic [39:0] out_div_in = 40'h0;
  logic [14:0] out_src_in = 15'h0;
  logic [4:0]  out_en_in = 5'h0, out_inv_in = 5'h0, clk_out, clk_oe_out;
  logic [9:0]  out_slew_in = 10'h0, out_slew_out;
  logic        spread_enable_n_in = 1'b1, spread_std_mode_in = 1'b0;
  logic [10:0] spread_cycles_in = 11'h010;
  logic [10:0] spread_amplitude_in = 11'h00a;
  logic [12:0] spread_mid_ratio_in = 13'h0a0;
  logic        crystal_osc_enable_n_in = 1'b0;
  logic        sleep_out, spread_active_out;
  logic [3:0]  pll_tick_out;
  logic [4:0][7:0] edges;
  int          mismatches = 0, compares = 0, cycles = 0;
  pdsc_row_t   rows [9] = '{
    '{0, 3'h4, 8'h01, 4'h1, 11'h040, 8'h01, 1'b0, 8'h40},
    '{1, 3'h0, 8'h02, 4'h2, 11'h010, 8'h01, 1'b0, 8'h10},
    '{2, 3'h1, 8'h01, 4'h2, 11'h020, 8'h01, 1'b0, 8'h20},
    '{3, 3'h2, 8'h04, 4'h1, 11'h040, 8'h01, 1'b0, 8'h10},
    '{4, 3'h3, 8'h01, 4'h4, 11'h010, 8'h02, 1'b0, 8'h20},
    '{0, 3'h3, 8'h02, 4'h1, 11'h400, 8'h20, 1'b0, 8'h10},
    '{2, 3'h4, 8'h08, 4'h1, 11'h040, 8'h01, 1'b0, 8'h08},
    '{1, 3'h5, 8'h01, 4'h1, 11'h040, 8'h01, 1'b1, 8'h00},
    '{3, 3'h4, 8'h01, 4'h1, 11'h040, 8'h01, 1'b1, 8'h40}};
  cg_clock_gen dut (.mclk_in, .rst_n_in, .cfg_sel_in, .cfg_wr_in,
    .cfg_slot_in, .ref_div_in, .fb_div_in, .feedback_prescale_a_in,
    .feedback_prescale_d_in, .loop_zero_resistor_in, .loop_zero_capacitor_in,
    .loop_pole_capacitor_in, .charge_pump_current_in, .out_div_in,
    .out_src_in, .out_en_in, .out_slew_in, .out_inv_in, .spread_enable_n_in,
    .spread_std_mode_in, .spread_cycles_in, .spread_mid_ratio_in,
    .spread_amplitude_in, .crystal_osc_enable_n_in, .clk_out, .clk_oe_out,
    .out_slew_out, .loop_zero_resistor_out, .loop_zero_capacitor_out,
    .loop_pole_capacitor_out, .charge_pump_current_out, .sleep_out,
    .spread_active_out, .pll_tick_out);
  pdsc_consumer far (.mclk_in(mclk_in), .clear_in(clear_r), .clk_in(clk_out),
    .edges_out(edges));
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Edge counts over a window may differ by one from phase alone.
  task automatic near(input logic [7:0] got, input logic [7:0] exp);
    if (got === exp + 8'h01 || got + 8'h01 === exp)
      chk(20'h0, 20'h0);
    else
      chk({12'h0, got}, {12'h0, exp});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic load(input pdsc_row_t r, input logic [4:0] tag,
                      input logic [1:0] slot);
    cfg_slot_in = slot;
    ref_div_in = {4{r.rdiv}};
    fb_div_in = {4{r.fb}};
    feedback_prescale_a_in = r.pre;
    feedback_prescale_d_in = r.pre;
    loop_zero_resistor_in = {4{tag}};
    loop_zero_capacitor_in = {4{tag[2:0]}};
    loop_pole_capacitor_in = {4{tag[1:0]}};
    charge_pump_current_in = {4{~tag[2:0]}};
    out_div_in = {5{r.output_divide_total}};
    out_src_in = {5{r.src}};
    out_en_in = 5'h01 << r.k;
    out_slew_in = {5{tag[1:0]}};
    out_inv_in = {5{r.inv}};
    cfg_wr_in = 1'b1;
    wait_cyc(1);
    cfg_wr_in = 1'b0;
    wait_cyc(8);
  endtask
  task automatic measure;
    clear_r = 1'b1;
    wait_cyc(1);
    clear_r = 1'b0;
    wait_cyc(128);
  endtask
  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      test_done;
    end
  end
  initial
  begin
    pdsc_row_t sp;
    rst_n_in = 1'b0;
    cfg_wr_in = 1'b0;
    wait_cyc(5);
    rst_n_in = 1'b1;
    wait_cyc(12);
    measure;
    chk(clk_oe_out, 5'h08);
    near(edges[3], 8'h40);
    near(edges[0], 8'h00);
    cfg_sel_in = 2'h1;
    for (int i = 0; i < 9; i++)
    begin
      load(rows[i], i[4:0], 2'h1);
      measure;
      near(edges[rows[i].k], rows[i].exp);
      chk(clk_oe_out, 5'h01 << rows[i].k);
      chk(out_slew_out, {5{i[1:0]}});
      chk(loop_zero_resistor_out, {4{i[4:0]}});
      chk(loop_zero_capacitor_out, {4{i[2:0]}});
      chk(loop_pole_capacitor_out, {4{i[1:0]}});
      chk(charge_pump_current_out, {4{~i[2:0]}});
      if (rows[i].exp == 8'h00)
        chk(clk_out[rows[i].k], rows[i].inv);
    end
    load(rows[0], 5'h00, 2'h2);
    chk(clk_oe_out, 5'h08);
    cfg_sel_in = 2'h2;
    wait_cyc(8);
    chk(clk_oe_out, 5'h01);
    cfg_sel_in = 2'h0;
    wait_cyc(8);
    chk({sleep_out, clk_oe_out, pll_tick_out}, 10'h200);
    cfg_sel_in = 2'h2;
    wait_cyc(8);
    measure;
    near(edges[0], 8'h40);
    sp = '{2, 3'h1, 8'h01, 4'h1, 11'h040, 8'h02, 1'b0, 8'h20};
    spread_enable_n_in = 1'b0;
    load(sp, 5'h00, 2'h2);
    measure;
    chk(spread_active_out, 1'b1);
    near(edges[2], 8'h20);
    spread_std_mode_in = 1'b1;
    load(sp, 5'h00, 2'h2);
    chk(spread_active_out, 1'b1);
    spread_enable_n_in = 1'b1;
    load(sp, 5'h00, 2'h2);
    chk(spread_active_out, 1'b0);
    // A stopped reference must freeze every source and the modulator.
    crystal_osc_enable_n_in = 1'b1;
    spread_enable_n_in = 1'b0;
    load(sp, 5'h00, 2'h2);
    measure;
    chk({spread_active_out, edges[2]}, 9'h000);
    crystal_osc_enable_n_in = 1'b0;
    // A reset in mid-run brings every slot back to the default setup.
    rst_n_in = 1'b0;
    wait_cyc(3);
    rst_n_in = 1'b1;
    wait_cyc(12);
    chk({sleep_out, clk_oe_out}, 6'h08);
    measure;
    near(edges[3], 8'h40);
    test_done;
  end
endmodule
`default_nettype wire
